// ### src/hppm_defs.svh
`ifndef HPPM_DEFS_SVH
`define HPPM_DEFS_SVH

// System configuration bits
`define HPPM_CFG_HOST 1
`define HPPM_CFG_TERT 2
`define HPPM_CFG_PORTB 5
`define HPPM_CFG_PORTC 7
`define HPPM_CFG_RST 8'h00

// Pin-mux control bits: daisy direction and memory pin swap
`define HPPM_MUX_DAISY 2
`define HPPM_MUX_MEM 3
`define HPPM_MUX_RST 8'h00

// Layout of the synchroniser vector
`define HPPM_SY_PA 0
`define HPPM_SY_PB 8
`define HPPM_SY_PC 16
`define HPPM_SY_CB 22
`define HPPM_SY_IRQ 29
`define HPPM_SY_DAISY 31

// Channel B pin positions within the shared group
`define HPPM_CB_RD 0
`define HPPM_CB_WR 1
`define HPPM_CB_DIS 2
`define HPPM_CB_A0 3
`define HPPM_CB_CS 6

// Port C input-only bits and the shared memory-write bit
`define HPPM_PC_IRQ1 6
`define HPPM_PC_IRQ2 7
`define HPPM_PC_MEMWR 2

`define HPPM_ALL8 8'hFF
`define HPPM_NONE8 8'h00

`endif

// ### src/hppm_pkg.sv
package hppm_pkg;

    typedef logic [7:0] hppm_byte_t;

    // Function on the three tertiary pins
    typedef enum logic [1:0] {
        TERT_CPU,
        TERT_CHANB,
        TERT_HOST
    } hppm_tert_t;

    // Whole state of the pin multiplexer
    typedef struct packed {
        logic [31:0] sync1;
        logic [31:0] sync2;
        hppm_byte_t sysCfg;
        hppm_byte_t pinMux;
        logic rdAct;
        logic wrAct;
        logic [1:0] irqPrev;
        logic [1:0] capLatch;
        logic hostWrPulse;
        logic hostRdPulse;
        logic [2:0] hostAddr;
        hppm_byte_t hostWrData;
        hppm_byte_t pAOut;
        hppm_byte_t pAOe;
        hppm_byte_t pBOut;
        hppm_byte_t pBOe;
        logic [5:0] pCOut;
        logic [5:0] pCOe;
        logic [6:0] cBOut;
        logic [6:0] cBOe;
        logic [2:0] tertOut;
        logic daisyOut;
        logic daisyOe;
        logic memRdPin;
        hppm_byte_t portARd;
        hppm_byte_t portBRd;
        hppm_byte_t portCRd;
        logic [6:0] chanBIn;
        logic [5:0] chanAIn;
        hppm_byte_t serBIn;
        logic daisyIn;
    } hppm_state_t;

endpackage : hppm_pkg

// ### src/hppm_pin_mux.sv
`timescale 1ns/1ps
`include "hppm_defs.svh"

// Function
// - Host mode: data lines carry host bytes
// - Driver-disable low during host read
// - Three-bit select picks emulated register
// - Host interrupt high while pending
// - DMA: transmit ready low when empty
// - DMA: receive ready low when byte waits
// - Port A bits individually in or out
// - Port B selectable, else serial functions
// - Port C 5:0 configurable, 7:6 irq levels
// - Writing one clears edge capture latch
// - Config bit picks port C or channel A
// - Non-host: host pins revert to channel B
// - Two bits choose tertiary pin function
// - Pin-mux bit turns daisy input to output
// - Pin-mux bit swaps memory read for request
// - Memory-write pin mux uses both registers
// - Memory-write strobe is default after reset
module hppm_pin_mux (
    input wire logic clock,
    input wire logic rst,
    // Configuration register writes
    input wire logic sysCfgWe,
    input wire hppm_pkg::hppm_byte_t sysCfgWrData,
    input wire logic pinMuxWe,
    input wire hppm_pkg::hppm_byte_t pinMuxWrData,
    // Port data and direction, 1 = output
    input wire hppm_pkg::hppm_byte_t portAData,
    input wire hppm_pkg::hppm_byte_t portADir,
    input wire hppm_pkg::hppm_byte_t portBData,
    input wire hppm_pkg::hppm_byte_t portBDir,
    input wire logic [5:0] portCData,
    input wire logic [5:0] portCDir,
    input wire logic portCWe,
    input wire hppm_pkg::hppm_byte_t portCWrData,
    input wire logic [1:0] irqEdgeMode,
    // Host-facing emulation side
    input wire hppm_pkg::hppm_byte_t hostRdData,
    input wire logic hostIrqPending,
    input wire logic hostDmaMode,
    input wire logic txHoldingEmpty,
    input wire logic rxByteWaiting,
    // Functions that share pins
    input wire hppm_pkg::hppm_byte_t serBOut,
    input wire hppm_pkg::hppm_byte_t serBOe,
    input wire logic [5:0] chanAOut,
    input wire logic [5:0] chanAOe,
    input wire logic [6:0] chanBOut,
    input wire logic [6:0] chanBOe,
    input wire logic [2:0] cpuTert,
    input wire logic [2:0] chanBTert,
    input wire logic daisyOutFn,
    input wire logic memWriteFn_n,
    input wire logic memReadFn_n,
    input wire logic memRequestFn_n,
    // Pad inputs
    input wire hppm_pkg::hppm_byte_t padAIn,
    input wire hppm_pkg::hppm_byte_t padBIn,
    input wire logic [5:0] padCIn,
    input wire logic [6:0] padChBIn,
    input wire logic extIrqOne_n,
    input wire logic extIrqTwo_n,
    input wire logic padDaisyIn,
    // Pad outputs
    output logic [7:0] padAOut,
    output logic [7:0] padAOe,
    output logic [7:0] padBOut,
    output logic [7:0] padBOe,
    output logic [5:0] padCOut,
    output logic [5:0] padCOe,
    output logic [6:0] padChBOut,
    output logic [6:0] padChBOe,
    output logic [2:0] padTert,
    output logic padDaisyOut,
    output logic padDaisyOe,
    output logic padMemRead,
    // Status toward the core
    output logic hostMode,
    output logic hostWrPulse,
    output logic hostRdPulse,
    output logic [2:0] hostAddr,
    output logic [7:0] hostWrData,
    output logic [7:0] portARd,
    output logic [7:0] portBRd,
    output logic [7:0] portCRd,
    output logic [1:0] irqCapture,
    output logic [6:0] chanBIn,
    output logic [5:0] chanAIn,
    output logic [7:0] serBIn,
    output logic daisyIn
);
    import hppm_pkg::*;

    hppm_state_t st_r;
    hppm_state_t st_nxt;

    logic [31:0] rawIn;
    logic isHost;
    logic selN;
    logic rdNow;
    logic wrNow;
    logic [1:0] irqSync;
    logic [1:0] irqFall;
    hppm_tert_t tertSel;
    hppm_byte_t portCBack;

    // Input-only bit reads its pin, output bit its written value
    function automatic hppm_byte_t readBack(hppm_byte_t pin, hppm_byte_t val,
                                           hppm_byte_t dir);
        readBack = (dir & val) | (~dir & pin);
    endfunction : readBack

    // Every pad input enters one two-stage synchroniser
    assign rawIn = {padDaisyIn, extIrqTwo_n, extIrqOne_n, padChBIn, padCIn, padBIn, padAIn};

    // Decoding from the second synchroniser stage only
    assign isHost = st_r.sysCfg[`HPPM_CFG_HOST];
    assign selN = st_r.sync2[`HPPM_SY_CB + `HPPM_CB_CS];
    assign rdNow = isHost && !selN && !st_r.sync2[`HPPM_SY_CB + `HPPM_CB_RD];
    assign wrNow = isHost && !selN && !st_r.sync2[`HPPM_SY_CB + `HPPM_CB_WR];
    assign irqSync = st_r.sync2[`HPPM_SY_IRQ +: 2];
    assign irqFall = st_r.irqPrev & ~irqSync;
    // Port C readback widened to a byte so the shared function fits it
    assign portCBack = readBack({2'b00, st_r.sync2[`HPPM_SY_PC +: 6]}, {2'b00, portCData},
                                {2'b00, portCDir});

    // Tertiary pins: host bit wins, then channel B bit
    always_comb begin
        if (st_r.sysCfg[`HPPM_CFG_HOST]) begin
            tertSel = TERT_HOST;
        end else if (st_r.sysCfg[`HPPM_CFG_TERT]) begin
            tertSel = TERT_CHANB;
        end else begin
            tertSel = TERT_CPU;
        end
    end

    // Next-state for the whole block
    always_comb begin
        st_nxt = st_r;
        st_nxt.sync1 = rawIn;
        st_nxt.sync2 = st_r.sync1;
        if (sysCfgWe) begin
            st_nxt.sysCfg = sysCfgWrData;
        end
        if (pinMuxWe) begin
            st_nxt.pinMux = pinMuxWrData;
        end

        // Host strobes: write data tracked while active, write pulse at its end, read pulse at its start
        st_nxt.rdAct = rdNow;
        st_nxt.wrAct = wrNow;
        st_nxt.hostRdPulse = rdNow && !st_r.rdAct;
        st_nxt.hostWrPulse = !wrNow && st_r.wrAct;
        if (wrNow || rdNow) begin
            st_nxt.hostAddr = st_r.sync2[`HPPM_SY_CB + `HPPM_CB_A0 +: 3];
        end
        if (wrNow) begin
            st_nxt.hostWrData = st_r.sync2[`HPPM_SY_PA +: 8];
        end

        // Port A pins or host data lines
        if (isHost) begin
            st_nxt.pAOut = hostRdData;
            st_nxt.pAOe = rdNow ? `HPPM_ALL8 : `HPPM_NONE8;
        end else begin
            st_nxt.pAOut = portAData;
            st_nxt.pAOe = portADir;
        end
        st_nxt.portARd = readBack(st_r.sync2[`HPPM_SY_PA +: 8], portAData, portADir);

        // Port B pins or serial functions
        if (st_r.sysCfg[`HPPM_CFG_PORTB]) begin
            st_nxt.pBOut = portBData;
            st_nxt.pBOe = portBDir;
        end else begin
            st_nxt.pBOut = serBOut;
            st_nxt.pBOe = serBOe;
        end
        st_nxt.portBRd = readBack(st_r.sync2[`HPPM_SY_PB +: 8], portBData, portBDir);
        st_nxt.serBIn = st_r.sync2[`HPPM_SY_PB +: 8];

        // Port C low bits or channel A modem signals
        if (st_r.sysCfg[`HPPM_CFG_PORTC]) begin
            st_nxt.pCOut = portCData;
            st_nxt.pCOe = portCDir;
        end else begin
            st_nxt.pCOut = chanAOut;
            st_nxt.pCOe = chanAOe;
        end
        // Shared memory-write pin stays a strobe until the mux bit moves it
        if (!st_r.pinMux[`HPPM_MUX_MEM]) begin
            st_nxt.pCOut[`HPPM_PC_MEMWR] = memWriteFn_n;
            st_nxt.pCOe[`HPPM_PC_MEMWR] = 1'b1;
        end
        st_nxt.chanAIn = st_r.sync2[`HPPM_SY_PC +: 6];
        st_nxt.portCRd[5:0] = portCBack[5:0];
        st_nxt.portCRd[`HPPM_PC_IRQ1] = irqSync[0];
        st_nxt.portCRd[`HPPM_PC_IRQ2] = irqSync[1];

        // Edge capture latches: a new edge beats a same-cycle clear
        st_nxt.irqPrev = irqSync;
        for (int i = 0; i < 2; i++) begin
            if (portCWe && portCWrData[`HPPM_PC_IRQ1 + i]) begin
                st_nxt.capLatch[i] = 1'b0;
            end
            if (irqEdgeMode[i] && irqFall[i]) begin
                st_nxt.capLatch[i] = 1'b1;
            end
            if (!irqEdgeMode[i]) begin
                st_nxt.capLatch[i] = 1'b0;
            end
        end

        // Channel B group: host inputs plus driver disable, or channel B
        if (isHost) begin
            st_nxt.cBOut = '1;
            st_nxt.cBOe = '0;
            st_nxt.cBOut[`HPPM_CB_DIS] = !rdNow;
            st_nxt.cBOe[`HPPM_CB_DIS] = 1'b1;
        end else begin
            st_nxt.cBOut = chanBOut;
            st_nxt.cBOe = chanBOe;
        end
        st_nxt.chanBIn = st_r.sync2[`HPPM_SY_CB +: 7];

        // Tertiary pins: interrupt, transmit ready, receive ready
        case (tertSel)
            TERT_HOST: begin
                st_nxt.tertOut[0] = hostIrqPending;
                st_nxt.tertOut[1] = !(hostDmaMode && txHoldingEmpty);
                st_nxt.tertOut[2] = !(hostDmaMode && rxByteWaiting);
            end
            TERT_CHANB: begin
                st_nxt.tertOut = chanBTert;
            end
            TERT_CPU: begin
                st_nxt.tertOut = cpuTert;
            end
            default: begin
                st_nxt.tertOut = cpuTert;
            end
        endcase

        // Daisy-chain pin and memory read pin
        st_nxt.daisyOe = st_r.pinMux[`HPPM_MUX_DAISY];
        st_nxt.daisyOut = daisyOutFn;
        st_nxt.daisyIn = st_r.sync2[`HPPM_SY_DAISY];
        st_nxt.memRdPin = st_r.pinMux[`HPPM_MUX_MEM] ? memRequestFn_n : memReadFn_n;

        if (rst) begin
            st_nxt = '0;
            st_nxt.sysCfg = `HPPM_CFG_RST;
            st_nxt.pinMux = `HPPM_MUX_RST;
            st_nxt.sync1 = '1;
            st_nxt.sync2 = '1;
            st_nxt.irqPrev = '1;
            st_nxt.cBOut = '1;
            st_nxt.tertOut = '1;
            st_nxt.memRdPin = 1'b1;
            st_nxt.pCOut[`HPPM_PC_MEMWR] = 1'b1;
            st_nxt.pCOe[`HPPM_PC_MEMWR] = 1'b1;
        end
    end

    // Single state register
    always_ff @(posedge clock) begin
        st_r <= st_nxt;
    end

    // Outputs straight from the state register
    assign padAOut = st_r.pAOut;
    assign padAOe = st_r.pAOe;
    assign padBOut = st_r.pBOut;
    assign padBOe = st_r.pBOe;
    assign padCOut = st_r.pCOut;
    assign padCOe = st_r.pCOe;
    assign padChBOut = st_r.cBOut;
    assign padChBOe = st_r.cBOe;
    assign padTert = st_r.tertOut;
    assign padDaisyOut = st_r.daisyOut;
    assign padDaisyOe = st_r.daisyOe;
    assign padMemRead = st_r.memRdPin;
    assign hostMode = st_r.sysCfg[`HPPM_CFG_HOST];
    assign hostWrPulse = st_r.hostWrPulse;
    assign hostRdPulse = st_r.hostRdPulse;
    assign hostAddr = st_r.hostAddr;
    assign hostWrData = st_r.hostWrData;
    assign portARd = st_r.portARd;
    assign portBRd = st_r.portBRd;
    assign portCRd = st_r.portCRd;
    assign irqCapture = st_r.capLatch;
    assign chanBIn = st_r.chanBIn;
    assign chanAIn = st_r.chanAIn;
    assign serBIn = st_r.serBIn;
    assign daisyIn = st_r.daisyIn;

    // Checks on the registered pin behaviour
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_xcvr_off_read: assert property (
        rdNow |=> (!padChBOut[`HPPM_CB_DIS] && padChBOe[`HPPM_CB_DIS]))
        else $error("driver disable not low during host read");

    a_data_drive: assert property (
        (rdNow && isHost) |=> (padAOe == `HPPM_ALL8 && padAOut == $past(hostRdData)))
        else $error("host data not driven during read");

    a_nosel_quiet: assert property (
        (selN && !st_r.wrAct && !st_r.rdAct) |=> (!hostWrPulse && !hostRdPulse))
        else $error("strobe taken without host select");

    a_wr_pulse: assert property (
        (wrNow ##1 !wrNow) |=> (hostWrPulse ##1 !hostWrPulse))
        else $error("write end pulse missing");

    a_rd_addr: assert property (
        (rdNow && !st_r.rdAct) |=> (hostRdPulse
            && hostAddr == $past(st_r.sync2[`HPPM_SY_CB + `HPPM_CB_A0 +: 3])))
        else $error("read pulse or register select wrong");

    a_tert_host: assert property (
        (tertSel == TERT_HOST) |=> (padTert[0] == $past(hostIrqPending)))
        else $error("host interrupt pin wrong");

    a_tx_ready: assert property (
        (tertSel == TERT_HOST && hostDmaMode && txHoldingEmpty) |=> !padTert[1])
        else $error("transmit ready not low");

    a_rx_ready: assert property (
        (tertSel == TERT_HOST && !(hostDmaMode && rxByteWaiting)) |=> padTert[2])
        else $error("receive ready low without byte");

    a_cap_clear: assert property (
        (portCWe && portCWrData[`HPPM_PC_IRQ1] && !irqFall[0]) |=> !irqCapture[0])
        else $error("capture latch not cleared by one");

    a_mem_default: assert property (
        (!st_r.pinMux[`HPPM_MUX_MEM] && !pinMuxWe)[*2] |=>
            (padCOut[`HPPM_PC_MEMWR] == $past(memWriteFn_n) && padCOe[`HPPM_PC_MEMWR]))
        else $error("memory write strobe lost on shared pin");

    a_chanb_rev: assert property (
        (!isHost && !sysCfgWe) |=> (padChBOe == $past(chanBOe)))
        else $error("channel B enables not restored");

    c_host_read: cover property (rdNow ##[1:20] !rdNow);
    c_host_write: cover property (hostWrPulse);
    c_irq_capture: cover property (irqCapture[1] ##[1:10] !irqCapture[1]);

endmodule : hppm_pin_mux

// ### test/hppm_host_model.sv
`timescale 1ns/1ps
// Host bus controller on the far side of the emulated register port
module hppm_host_model (
    input wire logic clock,
    input wire logic [7:0] dataIn,
    output logic [7:0] dataOut,
    output logic [6:0] pins
);
    logic writing;
    logic [7:0] lastByte;

    // Released data bus shows the inverse of the last byte, never a stale copy
    assign dataOut = writing ? lastByte : ~lastByte;

    initial begin
        writing = 1'b0;
        lastByte = 8'h00;
        pins = 7'h7F;
    end

    // Open an access: select, register address, one strobe, write byte
    task automatic hostStart(input logic rd, input logic [2:0] addr, input logic [7:0] wd,
                             input logic sel);
        @(negedge clock);
        pins[5:3] = addr;
        pins[6] = ~sel;
        pins[0] = ~rd;
        pins[1] = rd;
        lastByte = wd;
        writing = ~rd;
    endtask : hostStart

    // Close the access; caller keeps strobes up for at least 3 cycles first
    task automatic hostStop(output logic [7:0] rdByte);
        rdByte = dataIn;
        pins = 7'h7F;
        writing = 1'b0;
    endtask : hostStop
endmodule : hppm_host_model

// ### test/hppm_pin_mux_tb_top.sv
`timescale 1ns/1ps
module hppm_pin_mux_tb_top;
    import hppm_pkg::*;
    logic clock = 1'b0, rst = 1'b1, sysCfgWe = 1'b0, pinMuxWe = 1'b0, portCWe = 1'b0;
    hppm_byte_t sysCfgWrData = 8'h00, pinMuxWrData = 8'h00, portCWrData = 8'h00;
    hppm_byte_t portAData = 8'hA5, portADir = 8'h0F, portBData = 8'h3C, portBDir = 8'hF0;
    hppm_byte_t hostRdData = 8'h96, serBOut = 8'hC3, serBOe = 8'hAA, padBIn = 8'h5A;
    logic [5:0] portCData = 6'h2A, portCDir = 6'h3F, chanAOut = 6'h15, chanAOe = 6'h33;
    logic [5:0] padCIn = 6'h2C;
    logic [6:0] chanBOut = 7'h55, chanBOe = 7'h04;
    logic [2:0] cpuTert = 3'h6, chanBTert = 3'h2;
    logic [1:0] irqEdgeMode = 2'h0;
    logic hostIrqPending = 1'b1, hostDmaMode = 1'b1, txHoldingEmpty = 1'b1;
    logic rxByteWaiting = 1'b0, daisyOutFn = 1'b1, memWriteFn_n = 1'b1;
    logic memReadFn_n = 1'b0, memRequestFn_n = 1'b1, extIrqOne_n = 1'b1;
    logic extIrqTwo_n = 1'b1, padDaisyIn = 1'b1;
    logic [7:0] padAOut, padAOe, padBOut, padBOe, hostWrData, portARd, portBRd, portCRd;
    logic [7:0] serBIn, padAIn, hostData, rdByte;
    logic [6:0] padChBOut, padChBOe, chanBIn, padChBIn, hostPins;
    logic [5:0] padCOut, padCOe, chanAIn;
    logic [2:0] padTert, hostAddr;
    logic [1:0] irqCapture;
    logic padDaisyOut, padDaisyOe, padMemRead, hostMode, hostWrPulse, hostRdPulse, daisyIn;
    int err_count = 0, samples_checked = 0, cycles = 0, rdPulses = 0, wrPulses = 0;

    // Wire levels resolved from the block's pad enables, host driving the rest
    assign padAIn = (padAOe & padAOut) | (~padAOe & hostData);
    assign padChBIn = (padChBOe & padChBOut) | (~padChBOe & hostPins);

    always #25 clock = ~clock;

    hppm_pin_mux uut (
        .clock, .rst, .sysCfgWe, .sysCfgWrData, .pinMuxWe, .pinMuxWrData, .portAData,
        .portADir, .portBData, .portBDir, .portCData, .portCDir, .portCWe, .portCWrData,
        .irqEdgeMode, .hostRdData, .hostIrqPending, .hostDmaMode, .txHoldingEmpty,
        .rxByteWaiting, .serBOut, .serBOe, .chanAOut, .chanAOe, .chanBOut, .chanBOe,
        .cpuTert, .chanBTert, .daisyOutFn, .memWriteFn_n, .memReadFn_n, .memRequestFn_n,
        .padAIn, .padBIn, .padCIn, .padChBIn, .extIrqOne_n, .extIrqTwo_n, .padDaisyIn,
        .padAOut, .padAOe, .padBOut, .padBOe, .padCOut, .padCOe, .padChBOut, .padChBOe,
        .padTert, .padDaisyOut, .padDaisyOe, .padMemRead, .hostMode, .hostWrPulse,
        .hostRdPulse, .hostAddr, .hostWrData, .portARd, .portBRd, .portCRd, .irqCapture,
        .chanBIn, .chanAIn, .serBIn, .daisyIn
    );

    hppm_host_model host (
        .clock(clock),
        .dataIn(padAIn),
        .dataOut(hostData),
        .pins(hostPins)
    );

    // Pulse counters, so one-cycle pulses are never missed by a later look
    always @(posedge clock) begin
        if (hostRdPulse === 1'b1) begin
            rdPulses++;
        end
        if (hostWrPulse === 1'b1) begin
            wrPulses++;
        end
    end

    // Hang guard, well above the length of the sequence below
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(negedge clock);
    endtask : step

    // Both configuration writes in one cycle, then time for the pins to follow
    task automatic cfg(input logic [7:0] sys, input logic [7:0] mux);
        @(negedge clock);
        sysCfgWe = 1'b1;
        sysCfgWrData = sys;
        pinMuxWe = 1'b1;
        pinMuxWrData = mux;
        @(negedge clock);
        sysCfgWe = 1'b0;
        pinMuxWe = 1'b0;
        step(4);
    endtask : cfg

    task automatic portCWrite(input logic [7:0] d);
        @(negedge clock);
        portCWe = 1'b1;
        portCWrData = d;
        @(negedge clock);
        portCWe = 1'b0;
        step(1);
    endtask : portCWrite

    initial begin
        step(6);
        // Reset values, looked at before the first edge after release
        check(8'(padTert), 8'h07);
        check(8'({padMemRead, padCOut[2], padCOe[2]}), 8'h07);
        rst = 1'b0;
        memWriteFn_n = 1'b0;
        step(5);
        check(8'(padCOut[2]), 8'h00);
        // Plain mode: every shared pin on its first function
        check(padAOe, portADir);
        check(padAOut & padAOe, portAData & portADir);
        // Idle host shows all ones on the input half of port A
        check(portARd, 8'hF5);
        check(portBRd, 8'h3A);
        check(padBOut & padBOe, serBOut & serBOe);
        check(serBIn, 8'h5A);
        check(8'(padCOut & 6'h3B), 8'(chanAOut & 6'h3B));
        check(8'(padCOe), 8'h37);
        check(8'(chanAIn), 8'h2C);
        check(8'(padTert), 8'(cpuTert));
        check(8'({padChBOe, padChBOut[2]}), 8'h09);
        check(8'(chanBIn & 7'h7B), 8'h7B);
        check(8'({padMemRead, padDaisyOe, daisyIn}), 8'h01);
        check(8'(portCRd[7:6]), 8'h03);
        host.hostStart(1'b1, 3'h1, 8'h00, 1'b1);
        step(5);
        check(padAOe, portADir);
        check(8'(rdPulses), 8'h00);
        host.hostStop(rdByte);
        step(4);
        // Port functions, tertiary channel B, alternate daisy and memory pins
        cfg(8'hA4, 8'h0C);
        check(padBOut & padBOe, portBData & portBDir);
        check(8'(padCOut), 8'(portCData));
        check(8'(padCOe), 8'(portCDir));
        check(8'(portCRd[5:0]), 8'(portCData));
        check(8'(padTert), 8'(chanBTert));
        check(8'({padMemRead, padDaisyOe, padDaisyOut}), 8'h07);
        cfg(8'h24, 8'h08);
        check(8'(padCOut[2]), 8'(chanAOut[2]));
        // Edge capture on both interrupts: set, ignored zero, clearing ones
        irqEdgeMode = 2'h3;
        extIrqOne_n = 1'b0;
        step(6);
        check(8'(irqCapture), 8'h01);
        check(8'(portCRd[7:6]), 8'h02);
        extIrqTwo_n = 1'b0;
        step(6);
        check(8'(irqCapture), 8'h03);
        check(8'(portCRd[7:6]), 8'h00);
        extIrqOne_n = 1'b1;
        extIrqTwo_n = 1'b1;
        portCWrite(8'h00);
        check(8'(irqCapture), 8'h03);
        portCWrite(8'h40);
        check(8'(irqCapture), 8'h02);
        portCWrite(8'h80);
        check(8'(irqCapture), 8'h00);
        // Host mode: status lines, then a write and a read back to back
        cfg(8'h02, 8'h00);
        check(8'({hostMode, padTert}), 8'h0D);
        txHoldingEmpty = 1'b0;
        rxByteWaiting = 1'b1;
        step(2);
        check(8'(padTert), 8'h03);
        // Ready lines idle high outside DMA mode
        hostDmaMode = 1'b0;
        hostIrqPending = 1'b0;
        step(2);
        check(8'(padTert), 8'h06);
        // Read strobe without host select is ignored
        host.hostStart(1'b1, 3'h3, 8'h00, 1'b0);
        step(5);
        check(8'({padAOe, padChBOut[2]}), 8'h01);
        check(8'(rdPulses), 8'h00);
        check(8'(hostAddr), 8'h00);
        host.hostStop(rdByte);
        step(4);
        host.hostStart(1'b0, 3'h5, 8'h6C, 1'b1);
        step(4);
        check(8'(hostAddr), 8'h05);
        check(hostWrData, 8'h6C);
        host.hostStop(rdByte);
        step(4);
        check(8'(wrPulses), 8'h01);
        host.hostStart(1'b1, 3'h2, 8'h00, 1'b1);
        step(4);
        check(padAOe, 8'hFF);
        check(8'(padChBOut[2]), 8'h00);
        check(8'(rdPulses), 8'h01);
        check(8'(hostAddr), 8'h02);
        host.hostStop(rdByte);
        check(rdByte, hostRdData);
        step(4);
        check(8'({padAOe, padChBOut[2]}), 8'h01);
        end_of_test();
    end
endmodule : hppm_pin_mux_tb_top
